// ===== core/irq_mgr_pkg.sv
// Shared constants for the transceiver interrupt manager.
// Assumes a 40 MHz core clock and serial management frames of 32 bits.
package irq_mgr_pkg;

  // Register numbers on the serial management interface
  localparam logic [4:0] REG_BASIC_STATUS = 5'h01;
  localparam logic [4:0] REG_AN_EXPANSION = 5'h06;
  localparam logic [4:0] REG_FLAGS        = 5'h1D;
  localparam logic [4:0] REG_MASK         = 5'h1E;

  // Bit position of each source in the flag and mask registers
  localparam int SRC_PAGE  = 1;
  localparam int SRC_PDF   = 2;
  localparam int SRC_ACK   = 3;
  localparam int SRC_LINK  = 4;
  localparam int SRC_RFLT  = 5;
  localparam int SRC_ANC   = 6;
  localparam int SRC_ENRG  = 7;
  localparam int SRC_WAKE  = 8;

  // Reset values and writable bits; reserved bits read zero
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET  = 16'h0080;
  localparam logic [15:0] SRC_BITS    = 16'h01FE;
  localparam logic [15:0] PREV_RESET  = 16'h0010;

  // Serial frame layout
  localparam logic [5:0] PREAMBLE_LEN = 6'h20;
  localparam logic [1:0] OP_READ      = 2'h2;
  localparam logic [1:0] OP_WRITE     = 2'h1;
  localparam logic [3:0] HDR_LAST     = 4'hB;
  localparam logic [3:0] DATA_LAST    = 4'hF;

  // Timing of the late energy pulse
  localparam int CLK_KHZ      = 40000;
  localparam int LATE_DLY_MS  = 1000;
  localparam int LATE_PLS_MS  = 256;
  localparam int LATE_DLY_CYC = LATE_DLY_MS * CLK_KHZ;
  localparam int LATE_PLS_CYC = LATE_PLS_MS * CLK_KHZ;
  localparam int LATE_CNT_W   = 26;

  typedef enum logic [2:0] {
    SMI_IDLE   = 3'b000,
    SMI_START  = 3'b001,
    SMI_HEADER = 3'b011,
    SMI_TURN   = 3'b010,
    SMI_DATA   = 3'b110
  } smi_state_t;

  typedef enum logic [1:0] {
    LATE_IDLE  = 2'b00,
    LATE_ARMED = 2'b01,
    LATE_WAIT  = 2'b11,
    LATE_PULSE = 2'b10
  } late_state_t;

endpackage

// ===== core/bit_sync.sv
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs change slowly against clk.
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_t;

  sync_t st_reg;
  sync_t st_next;

  // Only the second stage is visible outside
  always_comb begin
    st_next.meta   = pin_in;
    st_next.stable = st_reg.meta;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = st_reg.stable;

endmodule

// ===== core/mgmt_serial_slave.sv
// Serial management frame engine: decodes frames, shifts read data out.
// Assumes mdc_rise marks each synchronised rising edge of the serial clock.
`timescale 1ns/1ps
module mgmt_serial_slave
  import irq_mgr_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        mdc_rise,
  input  wire logic        mdio_bit,
  input  wire logic [4:0]  phy_addr,
  input  wire logic        reg_mine,
  input  wire logic [15:0] rd_data,
  output logic [4:0]       frame_reg,
  output logic [15:0]      frame_wdata,
  output logic             rd_done,
  output logic             wr_done,
  output logic             mdio_out,
  output logic             mdio_oe
);

  typedef struct packed {
    smi_state_t  state;
    logic [5:0]  pre_cnt;
    logic [3:0]  bit_cnt;
    logic [11:0] hdr;
    logic        is_rd;
    logic        is_wr;
    logic [15:0] data;
    logic        dout;
    logic        doe;
    logic        rd_done;
    logic        wr_done;
  } smi_t;

  smi_t st_reg;
  smi_t st_next;
  logic [11:0] hdr_shift;

  assign hdr_shift = {st_reg.hdr[10:0], mdio_bit};

  // One step of the frame walk per serial clock edge
  always_comb begin
    st_next = st_reg;
    st_next.rd_done = 1'b0;
    st_next.wr_done = 1'b0;
    if (mdc_rise) begin
      unique case (st_reg.state)
        SMI_IDLE: begin
          if (mdio_bit) begin
            if (st_reg.pre_cnt != PREAMBLE_LEN) begin
              st_next.pre_cnt = st_reg.pre_cnt + 6'h01;
            end
          end else begin
            if (st_reg.pre_cnt == PREAMBLE_LEN) begin
              st_next.state = SMI_START;
            end
            st_next.pre_cnt = 6'h00;
          end
        end
        SMI_START: begin
          st_next.bit_cnt = 4'h0;
          st_next.state   = mdio_bit ? SMI_HEADER : SMI_IDLE;
        end
        SMI_HEADER: begin
          st_next.hdr     = hdr_shift;
          st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
          if (st_reg.bit_cnt == HDR_LAST) begin
            st_next.state   = SMI_TURN;
            st_next.bit_cnt = 4'h0;
            st_next.is_rd   = (hdr_shift[11:10] == OP_READ) &&
                              (hdr_shift[9:5] == phy_addr);
            st_next.is_wr   = (hdr_shift[11:10] == OP_WRITE) &&
                              (hdr_shift[9:5] == phy_addr);
          end
        end
        SMI_TURN: begin
          // Drive zero in the second turnaround slot, then data MSB first
          if (st_reg.bit_cnt == 4'h0) begin
            st_next.bit_cnt = 4'h1;
            st_next.doe     = st_reg.is_rd && reg_mine;
            st_next.dout    = 1'b0;
          end else begin
            st_next.state   = SMI_DATA;
            st_next.bit_cnt = 4'h0;
            st_next.data    = rd_data;
            st_next.dout    = rd_data[15];
          end
        end
        SMI_DATA: begin
          st_next.data    = {st_reg.data[14:0], mdio_bit};
          st_next.dout    = st_reg.data[14];
          st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
          if (st_reg.bit_cnt == DATA_LAST) begin
            st_next.state   = SMI_IDLE;
            st_next.doe     = 1'b0;
            st_next.rd_done = st_reg.is_rd;
            st_next.wr_done = st_reg.is_wr;
          end
        end
        default: begin
          st_next.state = SMI_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '{state: SMI_IDLE, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign frame_reg   = st_reg.hdr[4:0];
  assign frame_wdata = st_reg.data;
  assign rd_done     = st_reg.rd_done;
  assign wr_done     = st_reg.wr_done;
  assign mdio_out    = st_reg.dout;
  assign mdio_oe     = st_reg.doe;

endmodule

// ===== core/phy_interrupt_manager.sv
// Interrupt manager of the transceiver: flag and mask registers,
// primary and alternate clearing, late energy pulse, serial access.
// Assumes the status inputs come from logic on clk; serial pins do not.
`timescale 1ns/1ps
module phy_interrupt_manager
  import irq_mgr_pkg::*;
#(
  parameter int unsigned DELAY_CYC = LATE_DLY_CYC,
  parameter int unsigned PULSE_CYC = LATE_PLS_CYC
) (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe,
  input  wire logic [4:0] phy_addr,
  input  wire logic       alt_irq_mode_select,
  input  wire logic [3:0] wake_on_lan_event,
  input  wire logic       line_energy_detected,
  input  wire logic       an_complete,
  input  wire logic       remote_fault,
  input  wire logic       link_status,
  input  wire logic       partner_ack,
  input  wire logic       parallel_fault,
  input  wire logic       page_received,
  input  wire logic       an_restart,
  output logic            irq_out_n
);
  import irq_mgr_pkg::*;

  typedef struct packed {
    logic [15:0]           flags;
    logic [15:0]           mask;
    logic [15:0]           prev;
    logic                  mask_follow;
    late_state_t           late;
    logic [LATE_CNT_W-1:0] late_cnt;
    logic                  irq_n;
  } irq_t;

  irq_t st_reg;
  irq_t st_next;

  // Decode shared by the serial engine and the clearing logic
  function automatic logic hits(input logic [4:0] a, input logic [4:0] r);
    hits = (a == r);
  endfunction

  localparam logic [LATE_CNT_W-1:0] DLY_LAST =
    LATE_CNT_W'(DELAY_CYC - 1);
  localparam logic [LATE_CNT_W-1:0] PLS_LAST =
    LATE_CNT_W'(PULSE_CYC - 1);

  // Serial pins are asynchronous to clk
  logic [1:0] pins_sync;
  logic       mdc_q;

  bit_sync #(
    .W (2)
  ) u_sync (
    .clk      (clk),
    .rstn     (rstn),
    .pin_in   ({mdc, mdio_in}),
    .sync_out (pins_sync)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mdc_q <= 1'b0;
    end else begin
      mdc_q <= pins_sync[1];
    end
  end

  logic [4:0]  frame_reg;
  logic [15:0] frame_wdata;
  logic        rd_done;
  logic        wr_done;
  logic        reg_mine;
  logic [15:0] rd_data;

  assign reg_mine = hits(frame_reg, REG_FLAGS) || hits(frame_reg, REG_MASK);
  assign rd_data  = hits(frame_reg, REG_FLAGS) ? st_reg.flags :
                    hits(frame_reg, REG_MASK) ? st_reg.mask : 16'h0000;

  mgmt_serial_slave u_smi (
    .clk         (clk),
    .rstn        (rstn),
    .mdc_rise    (pins_sync[1] && !mdc_q),
    .mdio_bit    (pins_sync[0]),
    .phy_addr    (phy_addr),
    .reg_mine    (reg_mine),
    .rd_data     (rd_data),
    .frame_reg   (frame_reg),
    .frame_wdata (frame_wdata),
    .rd_done     (rd_done),
    .wr_done     (wr_done),
    .mdio_out    (mdio_out),
    .mdio_oe     (mdio_oe)
  );

  // Side effects fire only at the end of a whole frame to this address
  logic rd_flags;
  logic rd_bstat;
  logic rd_anexp;
  logic wr_flags;
  logic wr_mask;

  assign rd_flags = rd_done && hits(frame_reg, REG_FLAGS);
  assign rd_bstat = rd_done && hits(frame_reg, REG_BASIC_STATUS);
  assign rd_anexp = rd_done && hits(frame_reg, REG_AN_EXPANSION);
  assign wr_flags = wr_done && hits(frame_reg, REG_FLAGS);
  assign wr_mask  = wr_done && hits(frame_reg, REG_MASK);

  // Source levels, link down being the inverse of link status
  logic [15:0] act;
  logic [15:0] rise;
  logic [15:0] fall;
  logic [15:0] clr_pri;
  logic [15:0] clr_alt;
  logic [15:0] flags_upd;

  always_comb begin
    act = 16'h0000;
    act[SRC_WAKE] = |wake_on_lan_event;
    act[SRC_ENRG] = line_energy_detected;
    act[SRC_ANC]  = an_complete;
    act[SRC_RFLT] = remote_fault;
    act[SRC_LINK] = !link_status;
    act[SRC_ACK]  = partner_ack;
    act[SRC_PDF]  = parallel_fault;
    act[SRC_PAGE] = page_received;
  end

  // Primary mode deassert events per source
  always_comb begin
    clr_pri = 16'h0000;
    clr_pri[SRC_WAKE] = !act[SRC_WAKE] || rd_flags;
    clr_pri[SRC_ENRG] = fall[SRC_ENRG] || rd_flags;
    clr_pri[SRC_ANC]  = fall[SRC_ANC] || rd_flags;
    clr_pri[SRC_ACK]  = fall[SRC_ACK] || rd_flags;
    clr_pri[SRC_RFLT] = fall[SRC_RFLT] || rd_bstat || rd_flags;
    clr_pri[SRC_LINK] = rd_bstat || rd_flags;
    clr_pri[SRC_PDF]  = fall[SRC_PDF] || rd_anexp || rd_flags ||
                        an_restart || rise[SRC_LINK];
    clr_pri[SRC_PAGE] = fall[SRC_PAGE] || rd_anexp || rd_flags ||
                        an_restart || rise[SRC_LINK];
  end

  // Per-source edge detect and flag update; a new event beats a clear
  genvar gi;
  generate
    for (gi = SRC_PAGE; gi <= SRC_WAKE; gi++) begin : g_src
      assign rise[gi] = act[gi] && !st_reg.prev[gi];
      assign fall[gi] = !act[gi] && st_reg.prev[gi];
      // Write one asks for a recheck; clears only when source is idle
      assign clr_alt[gi] = wr_flags && frame_wdata[gi] && !act[gi];
      assign flags_upd[gi] = rise[gi] ||
        (st_reg.flags[gi] &&
         !(alt_irq_mode_select ? clr_alt[gi] : clr_pri[gi]));
    end
  endgenerate

  assign rise[0]            = 1'b0;
  assign fall[0]            = 1'b0;
  assign clr_alt[0]         = 1'b0;
  assign flags_upd[0]       = 1'b0;
  assign rise[15:9]         = 7'h00;
  assign fall[15:9]         = 7'h00;
  assign clr_alt[15:9]      = 7'h00;
  assign flags_upd[15:9]    = 7'h00;

  // Register update, late pulse sequencer and output level
  always_comb begin
    st_next       = st_reg;
    st_next.prev  = act & SRC_BITS;
    st_next.flags = flags_upd;
    if (wr_mask) begin
      st_next.mask        = frame_wdata & SRC_BITS;
      st_next.mask_follow = 1'b0;
    end else if (st_reg.mask_follow && fall[SRC_ENRG]) begin
      // Power-up mask bit clears on the first energy fall, unless software writes the mask first
      st_next.mask[SRC_ENRG] = 1'b0;
      st_next.mask_follow    = 1'b0;
    end
    unique case (st_reg.late)
      LATE_IDLE: begin
        // Armed when a read released the output with energy still high
        if (st_reg.mask[SRC_ENRG] && st_reg.flags[SRC_ENRG] &&
            !st_next.flags[SRC_ENRG] && act[SRC_ENRG]) begin
          st_next.late = LATE_ARMED;
        end
      end
      LATE_ARMED: begin
        if (!st_next.mask[SRC_ENRG]) begin
          st_next.late = LATE_IDLE;
        end else if (fall[SRC_ENRG]) begin
          st_next.late     = LATE_WAIT;
          st_next.late_cnt = '0;
        end
      end
      LATE_WAIT: begin
        st_next.late_cnt = st_reg.late_cnt + 1'b1;
        if (!st_next.mask[SRC_ENRG]) begin
          st_next.late = LATE_IDLE;
        end else if (st_reg.late_cnt == DLY_LAST) begin
          st_next.late     = LATE_PULSE;
          st_next.late_cnt = '0;
        end
      end
      LATE_PULSE: begin
        st_next.late_cnt = st_reg.late_cnt + 1'b1;
        if (st_reg.late_cnt == PLS_LAST) begin
          st_next.late = LATE_IDLE;
        end
      end
    endcase
    // Masked flags drive the pin; clearing a mask bit drops its term
    st_next.irq_n = !(|(st_next.flags & st_next.mask) ||
                      (st_next.late == LATE_PULSE));
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '{flags: FLAGS_RESET, mask: MASK_RESET,
                  prev: PREV_RESET, mask_follow: 1'b1,
                  late: LATE_IDLE, late_cnt: '0, irq_n: 1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign irq_out_n = st_reg.irq_n;

  // Checks on the live behaviour
  a_irq_follows: assert property (
    @(posedge clk) disable iff (!rstn)
    (|(st_reg.flags & st_reg.mask)) |-> !irq_out_n)
    else $error("output high while an enabled flag is set");

  a_wake_latch: assert property (
    @(posedge clk) disable iff (!rstn)
    $rose(|wake_on_lan_event) |=> st_reg.flags[SRC_WAKE])
    else $error("wake edge not latched");

  a_energy_drop: assert property (
    @(posedge clk) disable iff (!rstn)
    (!alt_irq_mode_select && fall[SRC_ENRG])
      |=> !st_reg.flags[SRC_ENRG])
    else $error("energy flag kept after falling edge");

  a_read_clears: assert property (
    @(posedge clk) disable iff (!rstn)
    (!alt_irq_mode_select && rd_flags && !(|rise))
      |=> (st_reg.flags == 16'h0000) ##1 irq_out_n ||
          (st_reg.late == LATE_PULSE))
    else $error("flag read did not clear all flags");

  a_link_hold: assert property (
    @(posedge clk) disable iff (!rstn)
    (!alt_irq_mode_select && st_reg.flags[SRC_LINK] &&
     !rd_flags && !rd_bstat) |=> st_reg.flags[SRC_LINK])
    else $error("link down flag cleared without a read");

  a_restart_clr: assert property (
    @(posedge clk) disable iff (!rstn)
    (!alt_irq_mode_select && an_restart && !rise[SRC_PDF])
      |=> !st_reg.flags[SRC_PDF])
    else $error("restart did not clear parallel fault flag");

  a_alt_keep: assert property (
    @(posedge clk) disable iff (!rstn)
    (alt_irq_mode_select && wr_flags && st_reg.flags[SRC_ANC] &&
     an_complete) |=> st_reg.flags[SRC_ANC] [*2])
    else $error("alternate write cleared an active source");

  a_alt_clear: assert property (
    @(posedge clk) disable iff (!rstn)
    (alt_irq_mode_select && wr_flags && frame_wdata[SRC_LINK] &&
     link_status && !rise[SRC_LINK]) |=> !st_reg.flags[SRC_LINK])
    else $error("link flag not cleared with link up");

  a_pulse_len: assert property (
    @(posedge clk) disable iff (!rstn)
    (st_reg.late == LATE_PULSE && st_reg.late_cnt != PLS_LAST)
      |=> (st_reg.late == LATE_PULSE) && !irq_out_n)
    else $error("late pulse ended early");

  a_rflt_read: assert property (
    @(posedge clk) disable iff (!rstn)
    (!alt_irq_mode_select && rd_bstat && !rise[SRC_RFLT])
      |=> !st_reg.flags[SRC_RFLT])
    else $error("status read did not clear remote fault flag");

  a_page_clear: assert property (
    @(posedge clk) disable iff (!rstn)
    (!alt_irq_mode_select && (rd_anexp || an_restart || rise[SRC_LINK]) &&
     !rise[SRC_PAGE]) |=> !st_reg.flags[SRC_PAGE])
    else $error("page received flag survived its clear");

  a_mask_track: assert property (
    @(posedge clk) disable iff (!rstn)
    (st_reg.mask_follow && fall[SRC_ENRG] && !wr_mask)
      |=> !st_reg.mask[SRC_ENRG])
    else $error("power-up energy mask kept after energy fell");

  a_mask_cut: assert property (
    @(posedge clk) disable iff (!rstn)
    (wr_mask && !(|(frame_wdata & st_reg.flags)) && !(|rise) &&
     (st_next.late != LATE_PULSE)) |=> irq_out_n)
    else $error("output held by a source whose mask was cleared");

  a_flag_latch: assert property (
    @(posedge clk) disable iff (!rstn)
    (rise != 16'h0000)
      |=> ((st_reg.flags & $past(rise)) == $past(rise)))
    else $error("source edge not latched in its flag");

  a_alt_hold: assert property (
    @(posedge clk) disable iff (!rstn)
    (alt_irq_mode_select && st_reg.flags[SRC_ANC] && !wr_flags)
      |=> st_reg.flags[SRC_ANC])
    else $error("alternate mode flag cleared without a write");

endmodule

// ===== bench/smc_model.sv
// Station management controller model that drives serial frames.
// Assumes the bench resolves the shared data line with a pull-up.
`timescale 1ns/1ps
module smc_model (
  input  wire logic clk,
  input  wire logic mdio_line,
  output logic      mdc,
  output logic      smc_oe,
  output logic      smc_bit
);
  import irq_mgr_pkg::*;

  // Serial clock stands low and the line is released outside frames
  initial begin
    mdc     = 1'b0;
    smc_oe  = 1'b0;
    smc_bit = 1'b0;
  end

  // One bit: set up while low, sample just before the rise
  task automatic bit_cyc(input logic oe, input logic b, output logic s);
    @(posedge clk);
    mdc     <= 1'b0;
    smc_oe  <= oe;
    smc_bit <= b;
    repeat (8) @(posedge clk);
    @(negedge clk);
    s = mdio_line;
    @(posedge clk);
    mdc <= 1'b1;
    repeat (7) @(posedge clk);
  endtask

  // Whole frame; a fresh preamble each time since the engine needs it
  task automatic frame(input logic rd, input logic [4:0] adr,
                       input logic [4:0] rg, input logic [15:0] wd,
                       output logic [15:0] rdv);
    logic [13:0] hdr;
    logic        s;
    hdr = {2'b01, rd ? OP_READ : OP_WRITE, adr, rg};
    for (int i = 0; i < 32; i++) bit_cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
    bit_cyc(!rd, 1'b1, s);
    bit_cyc(!rd, 1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      bit_cyc(!rd, wd[i], s);
      rdv[i] = s;
    end
    @(posedge clk);
    mdc    <= 1'b0;
    smc_oe <= 1'b0;
  endtask
endmodule

// ===== bench/phy_interrupt_manager_tb.sv
// Self-checking bench for the transceiver interrupt manager.
// Assumes smc_model drives frames; status inputs are bench registers.
`timescale 1ns/1ps
module phy_interrupt_manager_tb;
  import irq_mgr_pkg::*;
  localparam int unsigned DLY = 20;
  localparam int unsigned PLS = 40;
  localparam logic [4:0]  PHY = 5'h03;

  logic        clk, rstn, mdc, mdio_line, mdio_out, mdio_oe;
  logic        smc_oe, smc_bit, alt, link, restart, irq_out_n;
  logic [3:0]  wake;
  logic [7:1]  st;
  logic [15:0] junk;
  int          n_fail, samples_checked;
  int          srcs[6] = '{7, 6, 5, 3, 2, 1};

  // Released line is pulled up, so it never echoes the last bit
  assign mdio_line = mdio_oe ? mdio_out : (smc_oe ? smc_bit : 1'b1);

  phy_interrupt_manager #(.DELAY_CYC(DLY), .PULSE_CYC(PLS)) u_dut (
    .clk, .rstn, .mdc, .mdio_in(mdio_line), .mdio_out, .mdio_oe,
    .phy_addr(PHY), .alt_irq_mode_select(alt),
    .wake_on_lan_event(wake), .line_energy_detected(st[7]),
    .an_complete(st[6]), .remote_fault(st[5]), .link_status(link),
    .partner_ack(st[3]), .parallel_fault(st[2]),
    .page_received(st[1]), .an_restart(restart), .irq_out_n
  );

  smc_model u_smc_model (
    .clk, .mdio_line, .mdc, .smc_oe, .smc_bit
  );

  // Clock at 25 ns
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Output settles a few clocks after its cause; sample mid-cycle
  task automatic irq(input logic e);
    repeat (4) @(posedge clk);
    @(negedge clk);
    check({15'h0000, irq_out_n}, {15'h0000, e});
  endtask

  task automatic rd(input logic [4:0] rg, input logic [15:0] e);
    logic [15:0] v;
    u_smc_model.frame(1'b1, PHY, rg, 16'h0000, v);
    check(v, e);
  endtask

  task automatic wr(input logic [4:0] rg, input logic [15:0] d);
    u_smc_model.frame(1'b0, PHY, rg, d, junk);
  endtask

  // Drive one status input on a clock edge
  task automatic put(input int i, input logic v);
    @(posedge clk);
    st[i] <= v;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard, well beyond the roughly 30k clocks the tests take
  initial begin
    repeat (80000) @(posedge clk);
    n_fail++;
    conclude();
  end

  // Main sequence
  initial begin
    rstn = 1'b0;
    alt = 1'b0;
    link = 1'b1;
    restart = 1'b0;
    wake = 4'h0;
    st = 7'h00;
    n_fail = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    irq(1'b1);
    rd(REG_MASK, MASK_RESET);
    rd(REG_FLAGS, FLAGS_RESET);
    // Power-up energy mask drops by itself once energy goes away
    put(7, 1'b1);
    irq(1'b0);
    put(7, 1'b0);
    irq(1'b1);
    rd(REG_MASK, 16'h0000);
    $display("test reset done");

    // Flags latch with every source masked off
    wr(REG_MASK, 16'h0000);
    put(6, 1'b1);
    irq(1'b1);
    rd(REG_FLAGS, 16'h0040);
    rd(REG_FLAGS, 16'h0000);
    put(6, 1'b0);
    wr(REG_MASK, 16'hFFFF);
    rd(REG_MASK, SRC_BITS);
    $display("test latch done");

    // Each edge source asserts, then releases on its falling edge
    foreach (srcs[i]) begin
      put(srcs[i], 1'b1);
      irq(1'b0);
      put(srcs[i], 1'b0);
      irq(1'b1);
    end
    @(posedge clk);
    wake <= 4'h4;
    irq(1'b0);
    @(posedge clk);
    wake <= 4'h0;
    irq(1'b1);
    $display("test edges done");

    // Link down alone holds through link up; basic status read clears
    @(posedge clk);
    link <= 1'b0;
    irq(1'b0);
    @(posedge clk);
    link <= 1'b1;
    irq(1'b0);
    put(5, 1'b1);
    irq(1'b0);
    u_smc_model.frame(1'b1, PHY, REG_BASIC_STATUS, 16'h0000, junk);
    irq(1'b1);
    put(5, 1'b0);
    put(2, 1'b1);
    put(1, 1'b1);
    irq(1'b0);
    @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    irq(1'b1);
    put(2, 1'b0);
    put(1, 1'b0);
    put(2, 1'b1);
    put(1, 1'b1);
    irq(1'b0);
    u_smc_model.frame(1'b1, PHY, REG_AN_EXPANSION, 16'h0000, junk);
    irq(1'b1);
    put(2, 1'b0);
    put(1, 1'b0);
    $display("test read clears done");

    // Energy flag read while energy stays high arms the late pulse
    put(7, 1'b1);
    irq(1'b0);
    rd(REG_FLAGS, 16'h0080);
    irq(1'b1);
    put(7, 1'b0);
    irq(1'b1);
    repeat (DLY) @(posedge clk);
    irq(1'b0);
    repeat (PLS) @(posedge clk);
    irq(1'b1);
    $display("test late pulse done");

    // Alternate mode: write one clears only once the source is idle
    @(posedge clk);
    alt <= 1'b1;
    put(6, 1'b1);
    irq(1'b0);
    wr(REG_FLAGS, 16'h0040);
    rd(REG_FLAGS, 16'h0040);
    put(6, 1'b0);
    irq(1'b0);
    wr(REG_FLAGS, 16'h0040);
    irq(1'b1);
    rd(REG_FLAGS, 16'h0000);
    @(posedge clk);
    link <= 1'b0;
    irq(1'b0);
    wr(REG_FLAGS, 16'h0010);
    rd(REG_FLAGS, 16'h0010);
    @(posedge clk);
    link <= 1'b1;
    wr(REG_FLAGS, 16'h0010);
    rd(REG_FLAGS, 16'h0000);
    put(3, 1'b1);
    irq(1'b0);
    wr(REG_MASK, 16'h01F6);
    irq(1'b1);
    rd(REG_FLAGS, 16'h0008);
    put(3, 1'b0);
    $display("test alternate done");

    // Back in primary mode a flags read clears again
    @(posedge clk);
    alt <= 1'b0;
    rd(REG_FLAGS, 16'h0008);
    rd(REG_FLAGS, 16'h0000);
    u_smc_model.frame(1'b0, PHY + 5'h01, REG_MASK, 16'hFFFF, junk);
    rd(REG_MASK, 16'h01F6);
    $display("test mode and address done");

    // Service routine drops the energy mask, so no late pulse follows
    put(7, 1'b1);
    irq(1'b0);
    wr(REG_MASK, 16'h0176);
    irq(1'b1);
    rd(REG_FLAGS, 16'h0080);
    put(7, 1'b0);
    repeat (DLY) @(posedge clk);
    irq(1'b1);
    $display("test service done");
    conclude();
  end
endmodule
